// ===== logic/boot_lock_regs.vh
`ifndef BOOT_LOCK_REGS_VH
`define BOOT_LOCK_REGS_VH

// ****************************************
// extra array offsets
// ****************************************
`define XA_BOOT_STATUS      7'h00
`define XA_USER_BOOT_VECTOR 7'h01
`define XA_SOFT_SECURITY    7'h05
`define XA_MAKER_CODE       7'h30
`define XA_FAMILY_CODE      7'h31
`define XA_MEMORY_CODE      7'h60
`define XA_NAME_CODE        7'h61

// ****************************************
// reset values and erase values
// ****************************************
`define XA_RESET_VALUE      8'hFF
`define HW_ERASED_VALUE     8'hFF
`define HW_DELIVERY_VALUE   8'hB8

// ****************************************
// hardware configuration and software security byte fields
// ****************************************
`define HW_DOUBLE_SPEED_BIT 7
`define HW_BOOT_JUMP_BIT    6
`define HW_OSC_HI           5
`define HW_OSC_LO           4
`define HW_LOCK_HI          2
`define HW_LOCK_LO          0
`define SW_LOCK_HI          1
`define SW_LOCK_LO          0

// ****************************************
// boot addresses and memory bounds
// ****************************************
`define BOOT_ADDR_APP       16'h0000
`define BOOT_ADDR_LOADER    16'hF400
`define INT_FLASH_TOP       16'h7FFF
`define INT_BOOT_BASE       16'hF400

// ****************************************
// oscillator codes and protection levels
// ****************************************
`define OSC_CODE_FORBIDDEN  2'h0
`define LEVEL_1             3'h1
`define LEVEL_2             3'h2
`define LEVEL_3             3'h3
`define LEVEL_4             3'h4

// ****************************************
// timing: cycles from reset release to capture
// ****************************************
`define CAPTURE_DELAY       2'h2

`endif

// ===== logic/boot_and_lock_config.v
`timescale 1ns/1ps
`include "boot_lock_regs.vh"

// Overview of operation
// - boot jump bit picks 0000h or F400h
// - bit 7 zero selects double speed
// - bits 5-4 set oscillator range; 00 forbidden
// - bits 2-0 lock bits; all ones unprotected
// - level 2+ blocks external table reads inside
// - level 2+ latches external access at reset
// - level 2+ refuses parallel programming
// - level 3 also refuses parallel verify
// - level 4 also forbids external execution
// - lock bit zero means programmed
// - hardware locks delivered at level 4
// - delivered byte: loader boot, standard, 32 MHz
// - chip erase clears flash and config byte
// - identification always readable over parallel
// - serial access gated by software bits only
// - read-only id copies at 30,31,60,61
// - first software lock refuses serial programming
// - both software locks refuse serial verify
module boot_and_lock_config #(
  parameter [7:0] MAKER_CODE  = 8'h11, // arbitrary value
  parameter [7:0] FAMILY_CODE = 8'h22, // arbitrary value
  parameter [7:0] MEMORY_CODE = 8'h33, // arbitrary value
  parameter [7:0] NAME_CODE   = 8'h44  // arbitrary value
) (
  input  wire        MCLK,
  input  wire        RST,
  input  wire [7:0]  NV_HW_CONFIG,
  input  wire        EXTERNAL_ACCESS_PIN,
  input  wire        CHIP_ERASE,
  input  wire        HW_CFG_WR,
  input  wire        HW_CFG_FROM_PAR,
  input  wire [7:0]  HW_CFG_WDATA,
  output wire        NV_HW_WR,
  output reg  [7:0]  NV_HW_WDATA,
  output reg         FLASH_ERASE,
  input  wire        XA_RD,
  input  wire        XA_WR,
  input  wire        XA_FROM_PAR,
  input  wire [6:0]  XA_ADDR,
  input  wire [7:0]  XA_WDATA,
  output reg  [7:0]  XA_RDATA,
  output reg         XA_ACK,
  output reg         XA_REFUSED,
  input  wire        CODE_TABLE_READ,
  input  wire        CODE_TABLE_FROM_EXT,
  input  wire [15:0] CODE_TABLE_ADDR,
  output wire        CODE_TABLE_BLOCK,
  output reg  [15:0] BOOT_ADDR,
  output reg         DOUBLE_SPEED_SELECT,
  output reg  [1:0]  OSC_RANGE_SEL,
  output reg         OSC_RANGE_BAD,
  output reg  [2:0]  HW_LEVEL,
  output reg  [2:0]  SW_LEVEL,
  output reg  [7:0]  HW_CONFIG_SECURITY,
  output wire        EXTERNAL_ACCESS,
  output reg         PAR_PROG_EN,
  output reg         PAR_VERIFY_EN,
  output reg         EXT_EXEC_EN,
  output reg         ISP_PROG_EN,
  output reg         ISP_VERIFY_EN,
  output reg         CONFIG_VALID
);

  // ****************************************
  // level decoders
  // ****************************************

  // highest programmed (zero) lock bit wins
  function [2:0] hw_level_of;
    input [2:0] lock;
    begin
      if (!lock[2])
        hw_level_of = `LEVEL_4;
      else if (!lock[1])
        hw_level_of = `LEVEL_3;
      else if (!lock[0])
        hw_level_of = `LEVEL_2;
      else
        hw_level_of = `LEVEL_1;
    end
  endfunction

  // second bit alone programmed is not a listed level; treated as open
  function [2:0] sw_level_of;
    input [1:0] lock;
    begin
      if (lock == 2'h0)
        sw_level_of = `LEVEL_3;
      else if (lock == 2'h2)
        sw_level_of = `LEVEL_2;
      else
        sw_level_of = `LEVEL_1;
    end
  endfunction

  // ****************************************
  // external access pin synchroniser
  // ****************************************

  reg       ea_meta;
  reg       ea_sync;
  reg       ea_latched;
  reg [1:0] cap_cnt;
  reg       ea_hold;

  // two stages before anything looks at the pin
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ea_meta <= 1'b0;
      ea_sync <= 1'b0;
    end else begin
      ea_meta <= EXTERNAL_ACCESS_PIN;
      ea_sync <= ea_meta;
    end
  end

  // ****************************************
  // capture at reset release
  // ****************************************

  wire [2:0] lvl_now  = hw_level_of(NV_HW_CONFIG[`HW_LOCK_HI:`HW_LOCK_LO]);
  wire       capture  = (cap_cnt == `CAPTURE_DELAY) && !CONFIG_VALID;

  // wait for the pin synchroniser to fill before sampling
  always @(posedge MCLK or posedge RST) begin
    if (RST)
      cap_cnt <= 2'h0;
    else if (cap_cnt != `CAPTURE_DELAY)
      cap_cnt <= cap_cnt + 2'h1;
  end

  // decoded values taken once and then held until next reset
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CONFIG_VALID        <= 1'b0;
      BOOT_ADDR           <= `BOOT_ADDR_LOADER;
      DOUBLE_SPEED_SELECT <= 1'b0;
      OSC_RANGE_SEL       <= 2'h3;
      OSC_RANGE_BAD       <= 1'b0;
      HW_LEVEL            <= `LEVEL_4;
      HW_CONFIG_SECURITY  <= `HW_DELIVERY_VALUE;
      ea_latched          <= 1'b0;
      ea_hold             <= 1'b1;
    end else if (capture) begin
      CONFIG_VALID        <= 1'b1;
      HW_CONFIG_SECURITY  <= NV_HW_CONFIG;
      if (NV_HW_CONFIG[`HW_BOOT_JUMP_BIT])
        BOOT_ADDR <= `BOOT_ADDR_APP;
      else
        BOOT_ADDR <= `BOOT_ADDR_LOADER;
      DOUBLE_SPEED_SELECT <= ~NV_HW_CONFIG[`HW_DOUBLE_SPEED_BIT];
      OSC_RANGE_SEL       <= NV_HW_CONFIG[`HW_OSC_HI:`HW_OSC_LO];
      OSC_RANGE_BAD       <= (NV_HW_CONFIG[`HW_OSC_HI:`HW_OSC_LO]
                              == `OSC_CODE_FORBIDDEN);
      HW_LEVEL            <= lvl_now;
      ea_latched          <= ea_sync;
      ea_hold             <= (lvl_now >= `LEVEL_2);
    end
  end

  // below level 2 the pin is followed live
  assign EXTERNAL_ACCESS = ea_hold ? ea_latched : ea_sync;

  // ****************************************
  // extra array store
  // ****************************************

  reg [7:0] boot_status;
  reg [7:0] user_boot_vector;
  reg [7:0] soft_security;

  wire xa_is_id = (XA_ADDR == `XA_MAKER_CODE) || (XA_ADDR == `XA_FAMILY_CODE) ||
                  (XA_ADDR == `XA_MEMORY_CODE) || (XA_ADDR == `XA_NAME_CODE);
  // parallel side: writes end at level 2, reads at level 3, ids stay open
  wire par_wr_ok = (HW_LEVEL < `LEVEL_2) && CONFIG_VALID;
  wire par_rd_ok = ((HW_LEVEL < `LEVEL_3) && CONFIG_VALID) || xa_is_id;
  // serial side never looks at the hardware lock bits
  wire xa_wr_ok  = XA_FROM_PAR ? par_wr_ok : 1'b1;
  wire xa_rd_ok  = XA_FROM_PAR ? par_rd_ok : 1'b1;

  // id copies ignore writes but answer the access
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      boot_status      <= `XA_RESET_VALUE;
      user_boot_vector <= `XA_RESET_VALUE;
      soft_security    <= `XA_RESET_VALUE;
    end else if (XA_WR && xa_wr_ok) begin
      case (XA_ADDR)
        `XA_BOOT_STATUS: begin
          boot_status <= XA_WDATA;
        end
        `XA_USER_BOOT_VECTOR: begin
          user_boot_vector <= XA_WDATA;
        end
        `XA_SOFT_SECURITY: begin
          // reserved bits forced high so a careless write cannot clear them
          soft_security <= {6'h3F, XA_WDATA[`SW_LOCK_HI:`SW_LOCK_LO]};
        end
        default: begin
          soft_security <= soft_security;
        end
      endcase
    end
  end

  // read mux, unmapped offsets read as erased
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      XA_RDATA <= 8'h00;
    end else if (XA_RD && xa_rd_ok) begin
      case (XA_ADDR)
        `XA_BOOT_STATUS:      XA_RDATA <= boot_status;
        `XA_USER_BOOT_VECTOR: XA_RDATA <= user_boot_vector;
        `XA_SOFT_SECURITY:    XA_RDATA <= soft_security;
        `XA_MAKER_CODE:       XA_RDATA <= MAKER_CODE;
        `XA_FAMILY_CODE:      XA_RDATA <= FAMILY_CODE;
        `XA_MEMORY_CODE:      XA_RDATA <= MEMORY_CODE;
        `XA_NAME_CODE:        XA_RDATA <= NAME_CODE;
        default:              XA_RDATA <= `XA_RESET_VALUE;
      endcase
    end
  end

  // one-cycle answer strobes
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      XA_ACK     <= 1'b0;
      XA_REFUSED <= 1'b0;
    end else begin
      XA_ACK     <= (XA_RD && xa_rd_ok) || (XA_WR && xa_wr_ok);
      XA_REFUSED <= (XA_RD && !xa_rd_ok) || (XA_WR && !xa_wr_ok);
    end
  end

  // ****************************************
  // software level, live from the security byte
  // ****************************************

  always @(posedge MCLK or posedge RST) begin
    if (RST)
      SW_LEVEL <= `LEVEL_1;
    else
      SW_LEVEL <= sw_level_of(soft_security[`SW_LOCK_HI:`SW_LOCK_LO]);
  end

  // ****************************************
  // access enables
  // ****************************************

  // everything shut until the configuration has been captured
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PAR_PROG_EN   <= 1'b0;
      PAR_VERIFY_EN <= 1'b0;
      EXT_EXEC_EN   <= 1'b0;
      ISP_PROG_EN   <= 1'b0;
      ISP_VERIFY_EN <= 1'b0;
    end else begin
      PAR_PROG_EN   <= CONFIG_VALID && (HW_LEVEL < `LEVEL_2);
      PAR_VERIFY_EN <= CONFIG_VALID && (HW_LEVEL < `LEVEL_3);
      EXT_EXEC_EN   <= CONFIG_VALID && (HW_LEVEL < `LEVEL_4);
      ISP_PROG_EN   <= CONFIG_VALID && (SW_LEVEL < `LEVEL_2);
      ISP_VERIFY_EN <= CONFIG_VALID && (SW_LEVEL < `LEVEL_3);
    end
  end

  // ****************************************
  // table reads from external code
  // ****************************************

  // internal space is user flash plus the loader region
  wire ctr_internal = (CODE_TABLE_ADDR <= `INT_FLASH_TOP) ||
                      (CODE_TABLE_ADDR >= `INT_BOOT_BASE);
  assign CODE_TABLE_BLOCK = CODE_TABLE_READ && CODE_TABLE_FROM_EXT && ctr_internal &&
                            (HW_LEVEL >= `LEVEL_2);

  // ****************************************
  // configuration byte writes and chip erase
  // ****************************************

  reg hw_wr;

  // erase always allowed; serial-path byte writes also pass at any lock level
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hw_wr       <= 1'b0;
      NV_HW_WDATA <= `HW_ERASED_VALUE;
      FLASH_ERASE <= 1'b0;
    end else begin
      FLASH_ERASE <= CHIP_ERASE;
      if (CHIP_ERASE) begin
        hw_wr       <= 1'b1;
        NV_HW_WDATA <= `HW_ERASED_VALUE;
      end else if (HW_CFG_WR && (!HW_CFG_FROM_PAR || PAR_PROG_EN)) begin
        hw_wr       <= 1'b1;
        NV_HW_WDATA <= HW_CFG_WDATA;
      end else begin
        hw_wr       <= 1'b0;
        NV_HW_WDATA <= NV_HW_WDATA;
      end
    end
  end

  // new byte takes effect only after the next reset
  assign NV_HW_WR = hw_wr;

endmodule

// ===== bench/boot_and_lock_config_chk.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module boot_and_lock_config_chk (
  input wire        MCLK,
  input wire        RST,
  input wire        CHIP_ERASE,
  input wire        NV_HW_WR,
  input wire [7:0]  NV_HW_WDATA,
  input wire        FLASH_ERASE,
  input wire        XA_RD,
  input wire        XA_FROM_PAR,
  input wire [6:0]  XA_ADDR,
  input wire        XA_ACK,
  input wire [15:0] BOOT_ADDR,
  input wire        DOUBLE_SPEED_SELECT,
  input wire [1:0]  OSC_RANGE_SEL,
  input wire        OSC_RANGE_BAD,
  input wire [2:0]  HW_LEVEL,
  input wire [7:0]  HW_CONFIG_SECURITY,
  input wire        EXTERNAL_ACCESS,
  input wire        PAR_PROG_EN,
  input wire        PAR_VERIFY_EN,
  input wire        EXT_EXEC_EN,
  input wire        CONFIG_VALID
);
  wire [7:0] h;
  wire [2:0] lvl;
  // lock bits are low active, the highest programmed one wins
  assign h = HW_CONFIG_SECURITY;
  assign lvl = !h[2] ? 3'h4 : !h[1] ? 3'h3 : !h[0] ? 3'h2 : 3'h1;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  a_boot_vector: assert property (CONFIG_VALID |-> BOOT_ADDR == (h[6] ? 16'h0000 : 16'hF400))
    else $error("boot address wrong");
  a_speed_mode: assert property (CONFIG_VALID |-> DOUBLE_SPEED_SELECT == !h[7])
    else $error("clock mode wrong");
  a_osc_range: assert property (CONFIG_VALID |-> OSC_RANGE_SEL == h[5:4] && OSC_RANGE_BAD == (h[5:4] == 2'h0))
    else $error("oscillator range wrong");
  a_lock_level: assert property (CONFIG_VALID |-> HW_LEVEL == lvl)
    else $error("lock level wrong");
  a_par_prog: assert property ($past(CONFIG_VALID) |-> PAR_PROG_EN == (HW_LEVEL < 3'h2))
    else $error("parallel program gate wrong");
  a_par_verify: assert property ($past(CONFIG_VALID) |-> PAR_VERIFY_EN == (HW_LEVEL < 3'h3))
    else $error("parallel verify gate wrong");
  a_ext_exec: assert property ($past(CONFIG_VALID) |-> EXT_EXEC_EN == (HW_LEVEL < 3'h4))
    else $error("external execution gate wrong");
  a_held_decode: assert property ($past(CONFIG_VALID) |-> $stable(h) && $stable(BOOT_ADDR) && $stable(HW_LEVEL))
    else $error("decoded value moved");
  a_pin_latched: assert property (CONFIG_VALID && $past(CONFIG_VALID) && HW_LEVEL >= 3'h2 |-> $stable(EXTERNAL_ACCESS))
    else $error("external access not latched");
  a_erase_pulse: assert property (CHIP_ERASE |=> FLASH_ERASE && NV_HW_WR && NV_HW_WDATA == 8'hFF)
    else $error("erase answer wrong");
  a_id_read: assert property (XA_RD && XA_FROM_PAR && (XA_ADDR == 7'h30 || XA_ADDR == 7'h31 || XA_ADDR == 7'h60 || XA_ADDR == 7'h61) |=> XA_ACK)
    else $error("id read refused");
  c_erase: cover property (CHIP_ERASE ##1 FLASH_ERASE);
  c_top_level: cover property (CONFIG_VALID && HW_LEVEL == 3'h4);
  c_open_level: cover property (CONFIG_VALID && HW_LEVEL == 3'h1);
endmodule
bind boot_and_lock_config boot_and_lock_config_chk chk (.*);

// ===== bench/nv_cells.sv
`timescale 1ns/1ps
// ****
// nonvolatile config cells
// ****
module nv_cells (
  input wire       MCLK,
  input wire       load,
  input wire [7:0] load_value,
  input wire       wr,
  input wire [7:0] wdata,
  output reg [7:0] cells
);
  // a bench load stands for the programmer setting the level after verify
  always @(posedge MCLK) begin
    if (load)
      cells <= load_value;
    else if (wr)
      cells <= wdata;
  end
endmodule

// ===== bench/test_boot_and_lock_config.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module test_boot_and_lock_config;
  reg        mclk = 1'b0, rst = 1'b1, pin = 1'b0, erase = 1'b0, cfg_wr = 1'b0, load = 1'b1;
  reg        xa_rd = 1'b0, xa_wr = 1'b0, xa_par = 1'b0, ct_rd = 1'b0, ct_ext = 1'b0;
  reg [7:0]  cfg_wd = 8'h00, xa_wd = 8'h00, load_v = 8'hB8, v;
  reg [6:0]  xa_adr = 7'h00, j;
  reg [15:0] ct_adr = 16'h0000;
  reg [2:0]  lvl, sl_e;
  reg [31:0] rnd;
  wire [7:0] cells, nvd, rdata, hsec;
  wire [15:0] ba;
  wire [2:0] hl, sl;
  wire [1:0] osc;
  wire       nvw, fe, ack, rf, blk, dss, bad, ea_o, ppe, pve, eee, ipe, ive, cv;
  integer    num_errors = 0, checks_done = 0, seed = 32'h8fd2d534, i;
  // ids come from the default arbitrary codes 11, 22, 33, 44
  boot_and_lock_config dut (.MCLK(mclk), .RST(rst), .NV_HW_CONFIG(cells), .EXTERNAL_ACCESS_PIN(pin),
    .CHIP_ERASE(erase), .HW_CFG_WR(cfg_wr), .HW_CFG_FROM_PAR(xa_par), .HW_CFG_WDATA(cfg_wd),
    .NV_HW_WR(nvw), .NV_HW_WDATA(nvd), .FLASH_ERASE(fe), .XA_RD(xa_rd), .XA_WR(xa_wr),
    .XA_FROM_PAR(xa_par), .XA_ADDR(xa_adr), .XA_WDATA(xa_wd), .XA_RDATA(rdata), .XA_ACK(ack),
    .XA_REFUSED(rf), .CODE_TABLE_READ(ct_rd), .CODE_TABLE_FROM_EXT(ct_ext), .CODE_TABLE_ADDR(ct_adr),
    .CODE_TABLE_BLOCK(blk), .BOOT_ADDR(ba), .DOUBLE_SPEED_SELECT(dss), .OSC_RANGE_SEL(osc),
    .OSC_RANGE_BAD(bad), .HW_LEVEL(hl), .SW_LEVEL(sl), .HW_CONFIG_SECURITY(hsec),
    .EXTERNAL_ACCESS(ea_o), .PAR_PROG_EN(ppe), .PAR_VERIFY_EN(pve), .EXT_EXEC_EN(eee),
    .ISP_PROG_EN(ipe), .ISP_VERIFY_EN(ive), .CONFIG_VALID(cv));
  nv_cells cells_model (.MCLK(mclk), .load(load), .load_value(load_v), .wr(nvw), .wdata(nvd), .cells(cells));
  initial forever #4 mclk = ~mclk;
  function [2:0] lev(input [2:0] b);
    lev = !b[2] ? 3'h4 : !b[1] ? 3'h3 : !b[0] ? 3'h2 : 3'h1;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %0t got %0h want %0h", $time, got, exp);
      end
    end
  endtask
  // cells are loaded while reset holds, so capture sees a settled byte
  task start(input [7:0] cfg, input ld);
    begin
      @(posedge mclk);
      rst <= 1'b1;
      load <= ld;
      load_v <= cfg;
      rnd = $random(seed);
      pin <= rnd[0];
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      load <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
    end
  endtask
  task xa(input r, input w, input p, input [6:0] a, input [7:0] d, input e);
    begin
      @(posedge mclk);
      xa_rd <= r;
      xa_wr <= w;
      xa_par <= p;
      xa_adr <= a;
      xa_wd <= d;
      @(posedge mclk);
      xa_rd <= 1'b0;
      xa_wr <= 1'b0;
      #1;
      chk({ack, rf}, {!e, e});
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // a hang counts as a mismatch
  initial begin
    #100000;
    num_errors = num_errors + 1;
    complete_run;
  end
  initial begin
    start(8'hB8, 1'b1);
    chk({hsec, hl, ba, dss, osc}, {8'hB8, 3'h4, 16'hF400, 1'b0, 2'h3});
    for (i = 0; i < 4; i = i + 1) begin
      xa(0, 1, 0, 7'h05, {6'h3F, i[1:0]}, 0);
      xa(1, 0, 0, 7'h05, 8'h00, 0);
      sl_e = i[0] ? 3'h1 : i[1] ? 3'h2 : 3'h3;
      repeat (2) @(posedge mclk);
      #1;
      chk({rdata, sl, ipe, ive}, {6'h3F, i[1:0], sl_e, sl_e < 3'h2, sl_e < 3'h3});
    end
    xa(0, 1, 0, 7'h00, 8'h00, 0);
    xa(1, 0, 0, 7'h00, 8'h00, 0);
    chk(rdata, 8'h00);
    xa(1, 0, 0, 7'h7F, 8'h00, 0);
    chk(rdata, 8'hFF);
    for (i = 0; i < 12; i = i + 1) begin
      rnd = $random(seed);
      v = rnd[7:0];
      // the first eight runs walk every lock pattern
      if (i < 8)
        v[2:0] = i[2:0];
      start(v, 1'b1);
      lvl = lev(v[2:0]);
      chk(hsec, v);
      chk({ba, dss, bad, osc, hl, cv}, {v[6] ? 16'h0000 : 16'hF400, !v[7], v[5:4] == 2'h0, v[5:4], lvl, 1'b1});
      chk({ppe, pve, eee}, {lvl < 3'h2, lvl < 3'h3, lvl < 3'h4});
      for (j = 0; j < 4; j = j + 1) begin
        @(posedge mclk);
        rnd = $random(seed);
        ct_rd <= rnd[1];
        ct_ext <= rnd[0];
        ct_adr <= j[1] ? 16'hF3FF + j[0] : 16'h7FFF + j[0];
        #1;
        chk(blk, ct_rd && ct_ext && (ct_adr <= 16'h7FFF || ct_adr >= 16'hF400) && lvl >= 3'h2);
        xa(1, 0, 1, j[1] ? 7'h5E + j : 7'h30 + j, 8'h00, 0);
        chk(rdata, 8'h11 * (j + 1));
      end
      xa(1, 0, 1, 7'h05, 8'h00, lvl >= 3'h3);
      xa(0, 1, 1, 7'h00, 8'h00, lvl >= 3'h2);
      @(posedge mclk);
      cfg_wr <= 1'b1;
      rnd = $random(seed);
      cfg_wd <= rnd[7:0];
      @(posedge mclk);
      cfg_wr <= 1'b0;
      #1;
      chk({nvw, nvd}, {lvl < 3'h2, lvl < 3'h2 ? cfg_wd : 8'hFF});
      // software path writes the byte whatever the hardware level
      @(posedge mclk);
      cfg_wr <= 1'b1;
      xa_par <= 1'b0;
      @(posedge mclk);
      cfg_wr <= 1'b0;
      #1;
      chk({nvw, nvd}, {1'b1, cfg_wd});
      @(posedge mclk);
      pin <= !pin;
      repeat (4) @(posedge mclk);
      #1;
      chk(ea_o, lvl >= 3'h2 ? !pin : pin);
      $display("test %0d done", i);
    end
    @(posedge mclk);
    erase <= 1'b1;
    @(posedge mclk);
    erase <= 1'b0;
    #1;
    chk({fe, nvw, nvd}, 10'h3FF);
    start(8'h00, 1'b0);
    chk({hsec, hl, ppe, ba}, {8'hFF, 3'h1, 1'b1, 16'h0000});
    complete_run;
  end
endmodule
